// ==== charger_irq_flags_and_masks.sv ====
// Interrupt flags and masks of the charger: operational flags, fault flags,
// their enable registers and the combined interrupt output.
// Assumes a serial front end outside turns host transfers into one-cycle
// read and write strobes on the byte register port below.
`timescale 1ns/1ns

// How it works
// [RL1] Enable bits 3, 2 and 1 of the fault mask put thermal, input and data overvoltage into the interrupt.
// [RL2] The interrupt output rises only for a set flag whose enable bit is 1.
// [RL3] Bit 7 of the event flags reads 1 until the host has marked configuration complete.
// [RL4] Bit 7 reads 0 once configuration complete has been written, which the host must do.
// [RL5] Bit 3 of the event flags follows whether a portable device is attached.
// [RL6] Bit 1 is set on every attach or detach change and cleared by reading the register.
// [RL7] Bit 0 is set when an ADC sampling finishes and cleared by reading the register.
// [RL8] With autoclear at 0 the fault flags stay latched until read; at 1 they drop when the cause goes away.
// [RL9] The thermal and overvoltage flags clear on read only if their condition is gone.
module charger_irq_flags_and_masks (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       CONFIGURED_SET,
  input  wire logic       PORTABLE_ATTACHED,
  input  wire logic       ADC_DONE_PULSE,
  input  wire logic       THERMAL_WARN_COND,
  input  wire logic       INPUT_OV_COND,
  input  wire logic       DATA_OVERVOLTAGE_FLAG_COND,
  output logic            IRQ
);

  typedef struct packed {
    logic [7:0] event_mask;
    logic [7:0] fault_mask;
    logic       configured;
    logic       attached;
    logic       attach_ev;
    logic       adc_done;
    logic [7:0] rdata;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  logic       rd_event;
  logic       rd_fault;
  logic [2:0] fault_cond;
  logic [2:0] fault_flag;
  logic [7:0] event_flags;
  logic [7:0] fault_flags;

  // Register hit on a read or write strobe
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs, input logic strobe);
    hit = strobe && (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // Fault condition flags
  // ----------------------------------------------------------------
  assign rd_event   = hit(REG_ADDR, charger_irq_pkg::OFS_EVENT_FLAGS, REG_RD);
  assign rd_fault   = hit(REG_ADDR, charger_irq_pkg::OFS_FAULT_FLAGS, REG_RD);
  assign fault_cond = {THERMAL_WARN_COND, INPUT_OV_COND, DATA_OVERVOLTAGE_FLAG_COND};

  // [RL9] Conditional read clear
  for (genvar i = 0; i < 3; i++) begin : g_fault
    fault_flag_cell u_cell (
      .clk       (CLK),
      .nrst      (NRST),
      .cond      (fault_cond[i]),
      .rd_clr    (rd_fault),
      .autoclear (s_q.event_mask[charger_irq_pkg::BIT_AUTOCLEAR]),
      .flag      (fault_flag[i])
    );
  end

  // Read views of both flag registers
  always_comb begin
    event_flags = 8'h00;
    event_flags[charger_irq_pkg::BIT_UNCONFIG]  = ~s_q.configured;
    event_flags[charger_irq_pkg::BIT_ATTACHED]  = s_q.attached;
    event_flags[charger_irq_pkg::BIT_ATTACH_EV] = s_q.attach_ev;
    event_flags[charger_irq_pkg::BIT_ADC_DONE]  = s_q.adc_done;
    fault_flags = 8'h00;
    fault_flags[charger_irq_pkg::BIT_THERMAL]   = fault_flag[2];
    fault_flags[charger_irq_pkg::BIT_INPUT_OV]  = fault_flag[1];
    fault_flags[charger_irq_pkg::BIT_DATA_OVERVOLTAGE_FLAG]   = fault_flag[0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Mask writes keep only implemented bits
    if (hit(REG_ADDR, charger_irq_pkg::OFS_EVENT_MASK, REG_WR)) begin
      s_d.event_mask = REG_WDATA & charger_irq_pkg::EVENT_MASK_BITS;
    end
    if (hit(REG_ADDR, charger_irq_pkg::OFS_FAULT_MASK, REG_WR)) begin
      s_d.fault_mask = REG_WDATA & charger_irq_pkg::FAULT_MASK_BITS;
    end
    // [RL3] [RL4] Configuration complete latch
    s_d.configured = s_q.configured | CONFIGURED_SET;
    // [RL5] Attach status follows the line
    s_d.attached = PORTABLE_ATTACHED;
    // [RL6] Change event, set wins over read
    s_d.attach_ev = (PORTABLE_ATTACHED != s_q.attached) | (s_q.attach_ev & ~rd_event);
    // [RL7] ADC done, set wins over read
    s_d.adc_done = ADC_DONE_PULSE | (s_q.adc_done & ~rd_event);
    // Read data captured on the strobe
    if (REG_RD) begin
      case (REG_ADDR)
        charger_irq_pkg::OFS_EVENT_MASK:  s_d.rdata = s_q.event_mask;
        charger_irq_pkg::OFS_FAULT_MASK:  s_d.rdata = s_q.fault_mask;
        charger_irq_pkg::OFS_EVENT_FLAGS: s_d.rdata = event_flags;
        charger_irq_pkg::OFS_FAULT_FLAGS: s_d.rdata = fault_flags;
        default:                          s_d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_q.event_mask <= charger_irq_pkg::EVENT_MASK_RST;
      s_q.fault_mask <= charger_irq_pkg::FAULT_MASK_RST;
      s_q.configured <= 1'b0;
      s_q.attached   <= 1'b0;
      s_q.attach_ev  <= 1'b0;
      s_q.adc_done   <= 1'b0;
      s_q.rdata      <= charger_irq_pkg::RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA = s_q.rdata;
  // [RL1] [RL2] Masked flags onto the interrupt
  assign IRQ = |(event_flags & s_q.event_mask & charger_irq_pkg::EVENT_IRQ_BITS) | |(fault_flags & s_q.fault_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fault_gate;
    @(posedge CLK) disable iff (!NRST)
      (s_q.fault_mask[charger_irq_pkg::BIT_THERMAL] && fault_flag[2]) |-> IRQ;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("enabled thermal flag gave no interrupt"); // [RL1]

  property p_irq_cause;
    @(posedge CLK) disable iff (!NRST)
      IRQ |-> ((s_q.attached && s_q.event_mask[charger_irq_pkg::BIT_EN_ATTACHED])
            || (s_q.attach_ev && s_q.event_mask[charger_irq_pkg::BIT_EN_ATTACH_EV])
            || (s_q.adc_done && s_q.event_mask[charger_irq_pkg::BIT_EN_ADC_DONE])
            || (fault_flag[2] && s_q.fault_mask[charger_irq_pkg::BIT_THERMAL])
            || (fault_flag[1] && s_q.fault_mask[charger_irq_pkg::BIT_INPUT_OV])
            || (fault_flag[0] && s_q.fault_mask[charger_irq_pkg::BIT_DATA_OVERVOLTAGE_FLAG]));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled flag"); // [RL2]

  property p_unconfig;
    @(posedge CLK) disable iff (!NRST)
      (REG_RD && REG_ADDR == charger_irq_pkg::OFS_EVENT_FLAGS && !s_q.configured)
      |=> REG_RDATA[charger_irq_pkg::BIT_UNCONFIG];
  endproperty
  a_unconfig: assert property (p_unconfig) else $error("unconfigured bit read 0"); // [RL3]

  property p_configured;
    @(posedge CLK) disable iff (!NRST)
      CONFIGURED_SET |=> ##1 (REG_RD && REG_ADDR == charger_irq_pkg::OFS_EVENT_FLAGS)
      |=> !REG_RDATA[charger_irq_pkg::BIT_UNCONFIG];
  endproperty
  a_configured: assert property (p_configured) else $error("unconfigured bit stuck after config"); // [RL4]

  property p_attached;
    @(posedge CLK) disable iff (!NRST)
      PORTABLE_ATTACHED [*2] |-> event_flags[charger_irq_pkg::BIT_ATTACHED];
  endproperty
  a_attached: assert property (p_attached) else $error("attach indicator wrong"); // [RL5]

  property p_attach_ev;
    @(posedge CLK) disable iff (!NRST)
      (PORTABLE_ATTACHED != $past(PORTABLE_ATTACHED)) |=> s_q.attach_ev;
  endproperty
  a_attach_ev: assert property (p_attach_ev) else $error("attach change not flagged"); // [RL6]

  property p_attach_clear;
    @(posedge CLK) disable iff (!NRST)
      (rd_event && PORTABLE_ATTACHED == s_q.attached) |=> !s_q.attach_ev;
  endproperty
  a_attach_clear: assert property (p_attach_clear) else $error("attach event not cleared by read"); // [RL6]

  property p_adc_clear;
    @(posedge CLK) disable iff (!NRST)
      (rd_event && !ADC_DONE_PULSE) |=> !s_q.adc_done;
  endproperty
  a_adc_clear: assert property (p_adc_clear) else $error("adc done not cleared by read"); // [RL7]

  property p_adc_set;
    @(posedge CLK) disable iff (!NRST) ADC_DONE_PULSE |=> s_q.adc_done;
  endproperty
  a_adc_set: assert property (p_adc_set) else $error("adc done lost"); // [RL7]

  property p_event_gate;
    @(posedge CLK) disable iff (!NRST)
      (s_q.adc_done && s_q.event_mask[charger_irq_pkg::BIT_EN_ADC_DONE]) |-> IRQ;
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("enabled adc done flag gave no interrupt"); // [RL2]

  property p_rdata_hold;
    @(posedge CLK) disable iff (!NRST) !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read"); // [RL3]

  property p_fault_read;
    @(posedge CLK) disable iff (!NRST) (rd_fault && INPUT_OV_COND) |=> fault_flag[1];
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("input overvoltage cleared while active"); // [RL9]

  property p_latch;
    @(posedge CLK) disable iff (!NRST)
      (fault_flag[0] && !rd_fault && !s_q.event_mask[charger_irq_pkg::BIT_AUTOCLEAR]) |=> fault_flag[0];
  endproperty
  a_latch: assert property (p_latch) else $error("data overvoltage flag not latched"); // [RL8]

endmodule : charger_irq_flags_and_masks

// ==== charger_irq_pkg.sv ====
// Constants for the charger interrupt flag and mask block.
// Assumes a byte-wide register port decoded at the printed offsets.
package charger_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_MASK = 8'h07; // Enables for the operational flags
  localparam logic [7:0] OFS_FAULT_MASK = 8'h09; // fault_interrupt_enables_two
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h0A; // operational_event_flags
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h0C; // Thermal and overvoltage flags

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_AUTOCLEAR   = 7;
  localparam int BIT_EN_ATTACHED = 3;
  localparam int BIT_EN_ATTACH_EV = 1;
  localparam int BIT_EN_ADC_DONE = 0;
  localparam int BIT_THERMAL     = 3;
  localparam int BIT_INPUT_OV    = 2;
  localparam int BIT_DATA_OVERVOLTAGE_FLAG     = 1;
  localparam int BIT_UNCONFIG    = 7;
  localparam int BIT_ATTACHED    = 3;
  localparam int BIT_ATTACH_EV   = 1;
  localparam int BIT_ADC_DONE    = 0;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EVENT_MASK_BITS = 8'h8B;
  localparam logic [7:0] FAULT_MASK_BITS = 8'h0E;
  localparam logic [7:0] EVENT_MASK_RST  = 8'h00;
  localparam logic [7:0] FAULT_MASK_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST       = 8'h00;
  // Event flags that may reach the interrupt (bit 7 never does)
  localparam logic [7:0] EVENT_IRQ_BITS  = 8'h0B;

endpackage : charger_irq_pkg

// ==== fault_flag_cell.sv ====
// One condition flag that latches an active condition while autoclear is 0 and follows the condition while autoclear is 1.
// Assumes cond is synchronous to clk and rd_clr is a one-cycle read strobe.
`timescale 1ns/1ns
module fault_flag_cell (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic cond,
  input  wire logic rd_clr,
  input  wire logic autoclear,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } cell_t;

  cell_t s_q;
  cell_t s_d;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  // [RL9] [RL8] Clear only when condition gone
  always_comb begin
    s_d = s_q;
    s_d.flag = cond | (s_q.flag & ~rd_clr & ~autoclear);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cell_hold_cond;
    @(posedge clk) disable iff (!nrst) cond |=> flag;
  endproperty
  a_cell_hold_cond: assert property (p_cell_hold_cond) else $error("flag lost while condition active"); // [RL9]

  property p_cell_latched;
    @(posedge clk) disable iff (!nrst) (flag && !rd_clr && !autoclear) |=> flag;
  endproperty
  a_cell_latched: assert property (p_cell_latched) else $error("latched flag dropped without read"); // [RL8]

  property p_cell_autoclr;
    @(posedge clk) disable iff (!nrst) (autoclear && !cond) |=> !flag;
  endproperty
  a_cell_autoclr: assert property (p_cell_autoclr) else $error("autoclear did not clear flag"); // [RL8]

  property p_cell_rdclr;
    @(posedge clk) disable iff (!nrst) (rd_clr && !cond) |=> !flag;
  endproperty
  a_cell_rdclr: assert property (p_cell_rdclr) else $error("resolved flag not cleared by read"); // [RL9]

endmodule : fault_flag_cell

// ==== host_model.sv ====
// Host model: register strobes and the configuration-complete mark.
// Assumes the device samples its strobes on the rising clock edge.
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  output logic            cfg_set
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cfg_set = 1'b0;
  end
  // One write strobe; released lines invert so stale values never look valid
  task wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr_byte
  // One read strobe; data is taken once the answering edge has passed
  task rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask : rd_byte
  task configure();
    @(negedge clk);
    cfg_set = 1'b1;
    @(negedge clk);
    cfg_set = 1'b0;
  endtask : configure
endmodule : host_model

// ==== tb_top.sv ====
// Testbench: host model, stimulus and an integer model of flags, masks and IRQ.
// Assumes read data is valid one cycle after the read strobe.
`timescale 1ns/1ns
module tb_top;
  logic       clk, nrst, wr, rd, cfg_set, attach, adc, th, iov, dov, irq;
  logic [7:0] addr, wdata, rdata, v;
  integer     fail_count, comparisons, cycles, seed, m_ev, m_ft, cfg, att, aev, adc_f, ft, cnow, i;

  host_model host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .cfg_set(cfg_set));
  charger_irq_flags_and_masks dut (.CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .CONFIGURED_SET(cfg_set), .PORTABLE_ATTACHED(attach),
    .ADC_DONE_PULSE(adc), .THERMAL_WARN_COND(th), .INPUT_OV_COND(iov), .DATA_OVERVOLTAGE_FLAG_COND(dov), .IRQ(irq));

  // 50 MHz clock and hang guard
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic irq_exp();
    return ((((att << 3) | (aev << 1) | adc_f) & m_ev & 8'h0B) != 0) || ((ft & m_ft) != 0);
  endfunction : irq_exp
  // One cycle for flags to land, then compare the interrupt line
  task settle();
    @(negedge clk);
    chk("IRQ", {7'h00, irq}, {7'h00, irq_exp()});
  endtask : settle
  task wm(input logic [7:0] a, input logic [7:0] d);
    host.wr_byte(a, d);
    if (a == 8'h07) m_ev = d & 8'h8B;
    if (a == 8'h09) m_ft = d & 8'h0E;
    settle();
  endtask : wm
  // Expected view of the event flag register
  function automatic logic [7:0] ev_exp();
    return 8'((cfg == 0 ? 128 : 0) | (att << 3) | (aev << 1) | adc_f);
  endfunction : ev_exp
  // Read, compare with the model, then apply read side effects
  task rdchk(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == 8'h07) e = m_ev[7:0];
    if (a == 8'h09) e = m_ft[7:0];
    if (a == 8'h0A) e = ev_exp();
    if (a == 8'h0C) e = ft[7:0];
    host.rd_byte(a, v);
    chk("REG_RDATA", v, e);
    if (a == 8'h0A) begin
      aev = 0;
      adc_f = 0;
    end
    if (a == 8'h0C) ft = ft & (cnow << 1);
  endtask : rdchk
  // Event flag read in the same cycle as a new ADC result: the set wins
  task rd_ev_adc();
    logic [7:0] e;
    e = ev_exp();
    fork
      host.rd_byte(8'h0A, v);
      begin
        @(negedge clk);
        adc = 1'b1;
        @(negedge clk);
        adc = 1'b0;
      end
    join
    chk("REG_RDATA", v, e);
    aev = 0;
    adc_f = 1;
    settle();
  endtask : rd_ev_adc
  task cond(input logic [2:0] f);
    {th, iov, dov} = f;
    cnow = f;
    ft = m_ev[7] ? (f << 1) : (ft | (f << 1));
    settle();
  endtask : cond
  task attach_to(input logic a);
    attach = a;
    if (att != a) aev = 1;
    att = a;
    settle();
  endtask : attach_to
  task final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    {fail_count, comparisons, cycles, m_ev, m_ft, cfg, att, aev, adc_f, ft, cnow} = '0;
    seed = 87877;
    {nrst, attach, adc, th, iov, dov} = '0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    settle();
    rdchk(8'h0A);
    rdchk(8'h07);
    rdchk(8'h09);
    rdchk(8'h05);
    wm(8'hFF, 8'hFF);
    wm(8'h07, 8'hFF);
    rdchk(8'h07);
    wm(8'h09, 8'hFF);
    rdchk(8'h09);
    wm(8'h09, 8'h00);
    wm(8'h07, 8'h0B);
    attach_to(1'b1);
    rdchk(8'h0A);
    rdchk(8'h0A);
    wm(8'h07, 8'h01);
    attach_to(1'b0);
    adc = 1'b1;
    @(negedge clk);
    adc = 1'b0;
    adc_f = 1;
    settle();
    rdchk(8'h0A);
    rd_ev_adc();
    rdchk(8'h0A);
    wm(8'h0A, 8'hFF);
    rdchk(8'h0A);
    for (i = 0; i < 3; i++) begin
      cond(3'h1 << i);
      wm(8'h09, 8'h0E & ~(8'h02 << i));
      wm(8'h09, 8'h02 << i);
      rdchk(8'h0C);
      cond(3'h0);
      rdchk(8'h0C);
      rdchk(8'h0C);
    end
    wm(8'h07, 8'h80);
    wm(8'h09, 8'h0E);
    cond(3'h7);
    cond(3'h0);
    rdchk(8'h0C);
    repeat (8) begin
      v = 8'($random(seed));
      wm(8'h09, v);
      cond(v[6:4]);
      rdchk(8'h09);
      rdchk(8'h0C);
    end
    host.configure();
    cfg = 1;
    rdchk(8'h0A);
    // Mid-run reset brings back idle masks, flags and the unconfigured mark
    {attach, adc, th, iov, dov} = '0;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    {m_ev, m_ft, cfg, att, aev, adc_f, ft, cnow} = '0;
    settle();
    rdchk(8'h0A);
    rdchk(8'h09);
    final_report();
  end
endmodule : tb_top
